// ---- hw/ofp_top.sv ----
// ofp_top: twelve-channel electronic fuse with AXI4-Lite registers
// assumes sense samples in mA and event demands on the system clock
// Functional notes
// [R1] tolerate high current for 20 us after switch-on
// [R2] after inrush, high limit trips the channel
// [R3] continuous limit must clear within set window
// [R4] continuous limit selectable 15, 20 or 25 A
// [R5] initial fuse delay at most 10 seconds
// [R6] after initial delay, overrun of fuse trips
// [R7] overrun time set from 25 to 250 ms
// [R8] steady level below continuous limit, max 50 A; code takes steadyMa unclamped, up to 65535 mA
// [R9] auto re-activate up to configured retry count
// [R10] wait configured milliseconds between retries
// [R11] manual mode drops event control, all off
// [R12] manual on command toggles the channel
// [R13] report present current per channel in mA
// [R14] twelve independent channels with own state
// [R15] retries exhausted latch off until re-commanded
`timescale 1ns/1ps
`default_nettype none
module ofp_top #(
  parameter int NCH = ofp_pkg::NUM_CH // channel count
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire ofp_pkg::ofp_axi_req_t axiReq, // bus master side
  output var ofp_pkg::ofp_axi_rsp_t axiRsp, // bus slave answers
  input wire logic [NCH-1:0][ofp_pkg::CUR_W-1:0] curMa, // sensed currents
  input wire logic [NCH-1:0] eventDemand, // event control requests
  output logic [NCH-1:0] switchOn // power switch drives
);
  import ofp_pkg::*;

  localparam logic [10:0] TICK_LAST = 11'(TICK_CYC - 1);
  localparam logic [4:0] MS_LAST = 5'(TICKS_PER_MS - 1);

  // refuse settings the decode or divider cannot serve
  if (NCH < 1 || NCH > 16 || TICK_CYC > 2048 || TICKS_PER_MS > 32) begin : g_bad
    $error("unsupported fuse block parameters");
  end

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : mergeStrb

  function automatic logic [15:0] clampVal(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampVal

  function automatic ofp_dec_t decodeAddr(input logic [31:0] a);
    ofp_dec_t d;
    logic [11:0] off;
    off = a[11:0] - CH_BASE;
    d.ch = off[CH_STRIDE_LSB +: 4];
    d.word = off[2 +: 3];
    d.glob = (a[31:4] == 28'h0) && (a[1:0] == 2'h0);
    d.isCh = (a[31:12] == 20'h0) && (a[11:0] >= CH_BASE) && (off[11:9] == 3'h0)
             && (int'(d.ch) < NCH) && (d.word <= CW_CUR) && (a[1:0] == 2'h0);
    return d;
  endfunction : decodeAddr

  ////////////////////////////////////////////////////////////////////
  // time base: 50 us tick and 1 ms tick
  logic [10:0] tickCnt_reg;
  logic [4:0] msDiv_reg;
  logic tick50, tickMs;

  assign tick50 = tickCnt_reg == TICK_LAST;
  assign tickMs = tick50 && (msDiv_reg == MS_LAST);

  always_ff @(posedge clk) begin
    if (rst || tick50) tickCnt_reg <= 11'h0;
    else tickCnt_reg <= tickCnt_reg + 11'h1;
  end

  always_ff @(posedge clk) begin
    if (rst || tickMs) msDiv_reg <= 5'h0;
    else if (tick50) msDiv_reg <= msDiv_reg + 5'h1;
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  logic awHeld_reg, wHeld_reg, bValid_reg;
  logic [31:0] awAddr_reg, wData_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bResp_reg;
  logic awReady, wReady, awFire, wFire, doWrite;
  ofp_dec_t wDec;

  assign awReady = !awHeld_reg && !bValid_reg;
  assign wReady = !wHeld_reg && !bValid_reg;
  assign awFire = axiReq.awvalid && awReady;
  assign wFire = axiReq.wvalid && wReady;
  assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
  assign wDec = decodeAddr(awAddr_reg);

  // capture address and data
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 32'h0;
    end else if (awFire) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= axiReq.awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
    end else if (wFire) begin
      wHeld_reg <= 1'b1;
      wData_reg <= axiReq.wdata;
      wStrb_reg <= axiReq.wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  // write response, error for unmapped addresses
  always_ff @(posedge clk) begin
    if (rst) begin
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      bResp_reg <= (wDec.glob || wDec.isCh) ? RESP_OKAY : RESP_SLVERR;
    end else if (axiReq.bready) begin
      bValid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register file
  logic manual_reg, manualNext;
  logic [NCH-1:0] enable_reg, manualOn_reg, toggleBits, demand, onVec, latVec;
  logic [31:0] cfgW_reg [NCH][4];
  logic [NCH-1:0][CUR_W-1:0] curReg_reg;
  logic [31:0] ctrlMerged, enMerged, togMerged;
  logic wHitCtrl, wHitEnable, wHitToggle;

  assign wHitCtrl = doWrite && wDec.glob && (awAddr_reg[11:0] == REG_CTRL);
  assign wHitEnable = doWrite && wDec.glob && (awAddr_reg[11:0] == REG_ENABLE);
  assign wHitToggle = doWrite && wDec.glob && (awAddr_reg[11:0] == REG_TOGGLE);
  assign ctrlMerged = mergeStrb(32'(manual_reg) << CTRL_MANUAL, wData_reg, wStrb_reg);
  assign enMerged = mergeStrb(32'(enable_reg), wData_reg, wStrb_reg);
  assign togMerged = mergeStrb(32'h0, wData_reg, wStrb_reg);
  assign toggleBits = togMerged[NCH-1:0];
  assign manualNext = wHitCtrl ? ctrlMerged[CTRL_MANUAL] : manual_reg;

  // mode and enable bits
  always_ff @(posedge clk) begin
    if (rst) begin
      manual_reg <= 1'b0;
      enable_reg <= '0;
    end else begin
      manual_reg <= manualNext;
      if (wHitEnable) enable_reg <= enMerged[NCH-1:0];
    end
  end

  // manual states: cleared on entry, toggled by on commands
  always_ff @(posedge clk) begin
    if (rst || (manualNext && !manual_reg)) manualOn_reg <= '0; // see [R11]
    else if (manual_reg && wHitToggle) manualOn_reg <= manualOn_reg ^ toggleBits; // see [R12]
  end

  // per-channel configuration words
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      for (int w = 0; w < 4; w++) begin
        if (rst) cfgW_reg[i][w] <= CFG_RESET[w];
        else if (doWrite && wDec.isCh && int'(wDec.ch) == i && int'(wDec.word) == w)
          cfgW_reg[i][w] <= mergeStrb(cfgW_reg[i][w], wData_reg, wStrb_reg) & CFG_MASK[w];
      end
    end
  end

  // live current readout
  always_ff @(posedge clk) begin
    if (rst) curReg_reg <= '0;
    else curReg_reg <= curMa; // see [R13]
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  logic rValid_reg;
  logic [31:0] rData_reg, rDataNext, gRead, cRead, statusWord;
  logic [1:0] rResp_reg;
  logic arReady, arFire, rOk;
  ofp_dec_t rDec;

  assign arReady = !rValid_reg;
  assign arFire = axiReq.arvalid && arReady;
  assign rDec = decodeAddr(axiReq.araddr);
  assign rOk = rDec.glob || rDec.isCh;
  assign statusWord = 32'(onVec) | (32'(latVec) << STAT_LAT_LSB);
  assign gRead = (axiReq.araddr[11:0] == REG_CTRL) ? (32'(manual_reg) << CTRL_MANUAL) :
                 (axiReq.araddr[11:0] == REG_STATUS) ? statusWord :
                 (axiReq.araddr[11:0] == REG_ENABLE) ? 32'(enable_reg) : 32'h0;
  assign cRead = (rDec.word == CW_CUR) ? 32'(curReg_reg[rDec.ch]) :
                 cfgW_reg[rDec.ch][rDec.word[1:0]];
  assign rDataNext = !rOk ? 32'h0 : (rDec.glob ? gRead : cRead);

  always_ff @(posedge clk) begin
    if (rst) begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0;
      rResp_reg <= RESP_OKAY;
    end else if (arFire) begin
      rValid_reg <= 1'b1;
      rData_reg <= rDataNext;
      rResp_reg <= rOk ? RESP_OKAY : RESP_SLVERR;
    end else if (axiReq.rready) begin
      rValid_reg <= 1'b0;
    end
  end

  assign axiRsp = '{awready: awReady, wready: wReady, bvalid: bValid_reg,
                    bresp: bResp_reg, arready: arReady, rvalid: rValid_reg,
                    rdata: rData_reg, rresp: rResp_reg};

  ////////////////////////////////////////////////////////////////////
  // channels: each with its own limits, timers and retry state
  for (genvar i = 0; i < NCH; i++) begin : g_ch // see [R14]
    ofp_cfg_t chCfg;

    // event control is ignored while manual mode is on
    assign demand[i] = manual_reg ? manualOn_reg[i] : (enable_reg[i] | eventDemand[i]); // see [R11]
    assign chCfg = '{
      oclSel: cfgW_reg[i][0][1:0],
      oclWin: 12'(clampVal(16'(cfgW_reg[i][0][F_WIN_LSB +: 12]), OCL_WIN_MIN, OCL_WIN_MAX)), // see [R3]
      initMs: 14'(clampVal(16'(cfgW_reg[i][1][13:0]), INITIAL_FUSE_DELAY_MIN, INITIAL_FUSE_DELAY_MAX)), // see [R5]
      overrunMs: 8'(clampVal(16'(cfgW_reg[i][1][F_OVR_LSB +: 8]), OVR_MS_MIN, OVR_MS_MAX)), // see [R7]
      steadyMa: cfgW_reg[i][2][15:0],
      retryMax: cfgW_reg[i][2][F_RTY_LSB +: 4],
      retryMs: cfgW_reg[i][3][15:0]};

    ofp_channel u_ch (
      .clk(clk),
      .rst(rst),
      .tick50(tick50),
      .tickMs(tickMs),
      .demand(demand[i]),
      .curMa(curMa[i]),
      .cfg(chCfg),
      .outOn(onVec[i]),
      .faultLatched(latVec[i])
    );
  end

  assign switchOn = onVec;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_manual_clear: assert property ( // see [R11]
    $rose(manual_reg) |-> manualOn_reg == '0 ##1 switchOn == '0)
    else $error("manual entry did not switch all channels off");
  a_manual_events: assert property ( // see [R11]
    manual_reg && manualOn_reg == '0 && $stable(manualOn_reg) |=> switchOn == '0)
    else $error("events drove outputs in manual mode");
  a_toggle_flip: assert property ( // see [R12]
    manual_reg && wHitToggle |=> manualOn_reg == ($past(manualOn_reg) ^ $past(toggleBits)))
    else $error("manual command did not toggle channel");
  a_cur_track: assert property ( // see [R13]
    1'b1 |=> curReg_reg == $past(curMa))
    else $error("current readout lags the sense input");
  a_bresp_hold: assert property (
    bValid_reg && !axiReq.bready |=> bValid_reg && $stable(bResp_reg))
    else $error("write response dropped before bready");
  a_write_answer: assert property (
    doWrite |=> bValid_reg ##0 !awHeld_reg ##0 !wHeld_reg)
    else $error("write not answered one cycle after both halves");
  a_read_error: assert property (
    arFire && !rOk |=> rValid_reg && rResp_reg == RESP_SLVERR && rData_reg == 32'h0)
    else $error("unmapped read not answered with error");
  a_rdata_hold: assert property (
    rValid_reg && !axiReq.rready |=> rValid_reg && $stable(rData_reg))
    else $error("read data changed before rready");

  c_manual_toggle: cover property ($rose(manual_reg) ##[1:20] (manual_reg && wHitToggle));
  c_write_done: cover property (doWrite ##1 (bValid_reg && axiReq.bready));
  c_read_done: cover property (arFire ##1 (rValid_reg && axiReq.rready));

endmodule : ofp_top
`default_nettype wire

// ---- hw/ofp_pkg.sv ----
// ofp_pkg: constants, register map and types of the output fuse block
// assumes one 25 MHz system clock shared by bus, sense path and switches
package ofp_pkg;

  // channel count and current sample width (mA)
  localparam int NUM_CH = 12;
  localparam int CUR_W = 18;

  // timing: clock rate, inrush allowance, base tick
  localparam int CLK_KHZ = 25000;
  localparam int INRUSH_US = 20;
  localparam int INRUSH_CYC = (INRUSH_US * CLK_KHZ + 999) / 1000;
  localparam int TICK_US = 50;
  localparam int TICK_CYC = TICK_US * CLK_KHZ / 1000;
  localparam int TICKS_PER_MS = 1000 / TICK_US;

  // current limits in mA
  localparam logic [CUR_W-1:0] HIGH_LIMIT_MA = 18'h186a0;
  localparam logic [CUR_W-1:0] OCL_15_MA = 18'h03a98;
  localparam logic [CUR_W-1:0] OCL_20_MA = 18'h04e20;
  localparam logic [CUR_W-1:0] OCL_25_MA = 18'h061a8;
  localparam logic [1:0] OCL_SEL_15 = 2'h0;
  localparam logic [1:0] OCL_SEL_20 = 2'h1;

  // accepted ranges: window in 50 us ticks, others in ms
  localparam logic [15:0] OCL_WIN_MIN = 16'h0003;
  localparam logic [15:0] OCL_WIN_MAX = 16'h0c1c;
  localparam logic [15:0] INITIAL_FUSE_DELAY_MIN = 16'h0000;
  localparam logic [15:0] INITIAL_FUSE_DELAY_MAX = 16'h2710;
  localparam logic [15:0] OVR_MS_MIN = 16'h0019;
  localparam logic [15:0] OVR_MS_MAX = 16'h00fa;

  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_ENABLE = 12'h008;
  localparam logic [11:0] REG_TOGGLE = 12'h00c;
  localparam logic [11:0] CH_BASE = 12'h100;
  localparam int CH_STRIDE_LSB = 5;
  localparam logic [2:0] CW_CUR = 3'h4;

  // field positions
  localparam int CTRL_MANUAL = 0;
  localparam int STAT_LAT_LSB = 16;
  localparam int F_WIN_LSB = 16;
  localparam int F_OVR_LSB = 16;
  localparam int F_RTY_LSB = 16;

  // per-channel config words: writable bits and reset values
  localparam logic [3:0][31:0] CFG_MASK =
    {32'h0000ffff, 32'h000fffff, 32'h00ff3fff, 32'h0fff0003};
  localparam logic [3:0][31:0] CFG_RESET =
    {32'h00000064, 32'h000332c8, 32'h001900fa, 32'h00640002};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] oclSel;
    logic [11:0] oclWin;
    logic [13:0] initMs;
    logic [7:0] overrunMs;
    logic [15:0] steadyMa;
    logic [3:0] retryMax;
    logic [15:0] retryMs;
  } ofp_cfg_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } ofp_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ofp_axi_rsp_t;

  typedef struct packed {
    logic glob;
    logic isCh;
    logic [3:0] ch;
    logic [2:0] word;
  } ofp_dec_t;

  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_RETRY, ST_LATCH} ofp_state_t;

endpackage : ofp_pkg

// ---- hw/ofp_channel.sv ----
// ofp_channel: fuse state machine and timers of one output channel
// assumes current samples and tick pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module ofp_channel (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic tick50, // 50 us pulse
  input wire logic tickMs, // 1 ms pulse
  input wire logic demand, // channel wanted on
  input wire logic [ofp_pkg::CUR_W-1:0] curMa, // sensed current
  input wire ofp_pkg::ofp_cfg_t cfg, // limits and timers
  output logic outOn, // power switch drive
  output logic faultLatched // retries used up
);
  import ofp_pkg::*;

  localparam logic [9:0] INRUSH_N = 10'(INRUSH_CYC);

  ofp_state_t state_reg, state_next;
  logic [9:0] inrushCnt_reg;
  logic [11:0] winCnt_reg;
  logic [13:0] msCnt_reg;
  logic [7:0] overCnt_reg;
  logic [15:0] waitCnt_reg;
  logic [3:0] retries_reg;
  logic [CUR_W-1:0] oclLimit;
  logic isOn, entering, highTrip, oclTrip, overSteady, swTrip, trip;
  logic canRetry, waitDone, enterWait;

  ////////////////////////////////////////////////////////////////////
  // trip conditions, all timed from switch-on
  assign isOn = state_reg == ST_ON;
  assign oclLimit = (cfg.oclSel == OCL_SEL_15) ? OCL_15_MA :
                    (cfg.oclSel == OCL_SEL_20) ? OCL_20_MA : OCL_25_MA; // see [R4]
  assign highTrip = (inrushCnt_reg >= INRUSH_N) && (curMa >= HIGH_LIMIT_MA); // see [R1] [R2]
  assign oclTrip = (winCnt_reg >= cfg.oclWin) && (curMa >= oclLimit); // see [R3]
  assign overSteady = (msCnt_reg >= cfg.initMs) && (curMa > CUR_W'(cfg.steadyMa)); // see [R6]
  assign swTrip = overSteady && (overCnt_reg >= cfg.overrunMs); // see [R6] [R7]
  assign trip = isOn && (highTrip || oclTrip || swTrip);
  assign canRetry = retries_reg < cfg.retryMax; // see [R9]
  assign waitDone = waitCnt_reg >= cfg.retryMs; // see [R10]
  assign entering = (state_next == ST_ON) && !isOn;
  assign enterWait = (state_next == ST_RETRY) && (state_reg != ST_RETRY);

  // next state; dropping demand always wins
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: if (demand) state_next = ST_ON;
      ST_ON: if (!demand) state_next = ST_OFF;
        else if (trip) state_next = canRetry ? ST_RETRY : ST_LATCH; // see [R9]
      ST_RETRY: if (!demand) state_next = ST_OFF;
        else if (waitDone) state_next = ST_ON; // see [R10]
      ST_LATCH: if (!demand) state_next = ST_OFF; // see [R15]
      default: state_next = ST_OFF;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) state_reg <= ST_OFF;
    else state_reg <= state_next;
  end

  // on-time counters, restarted at every switch-on, saturating
  always_ff @(posedge clk) begin
    if (rst || entering) begin
      inrushCnt_reg <= 10'h0;
      winCnt_reg <= 12'h0;
      msCnt_reg <= 14'h0;
      overCnt_reg <= 8'h0;
    end else if (isOn) begin
      if (inrushCnt_reg != INRUSH_N) inrushCnt_reg <= inrushCnt_reg + 10'h1; // see [R1]
      if (tick50 && winCnt_reg != 12'hfff) winCnt_reg <= winCnt_reg + 12'h1;
      if (tickMs && msCnt_reg != 14'h3fff) msCnt_reg <= msCnt_reg + 14'h1;
      if (!overSteady) overCnt_reg <= 8'h0;
      else if (tickMs && overCnt_reg != 8'hff) overCnt_reg <= overCnt_reg + 8'h1;
    end
  end

  // retry interval counter and attempt count
  always_ff @(posedge clk) begin
    if (rst || enterWait) waitCnt_reg <= 16'h0;
    else if (tickMs && waitCnt_reg != 16'hffff) waitCnt_reg <= waitCnt_reg + 16'h1;
  end

  always_ff @(posedge clk) begin
    if (rst || state_reg == ST_OFF) retries_reg <= 4'h0;
    else if (trip && demand && canRetry) retries_reg <= retries_reg + 4'h1; // see [R9]
  end

  assign outOn = isOn;
  assign faultLatched = state_reg == ST_LATCH;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_inrush_allow: assert property ( // see [R1]
    isOn && demand && inrushCnt_reg < INRUSH_N && !oclTrip && !swTrip |=> isOn)
    else $error("channel tripped inside inrush allowance");
  a_high_trip: assert property ( // see [R2]
    isOn && demand && highTrip |=> state_reg inside {ST_RETRY, ST_LATCH})
    else $error("high limit did not switch channel off");
  a_ocl_trip: assert property ( // see [R3]
    isOn && demand && oclTrip |=> state_reg inside {ST_RETRY, ST_LATCH})
    else $error("continuous limit did not switch channel off");
  a_sw_trip: assert property ( // see [R6]
    isOn && demand && swTrip |=> !outOn ##0 state_reg != ST_OFF)
    else $error("software fuse did not switch channel off");
  a_retry_limit: assert property ( // see [R9]
    trip && demand && !canRetry |=> faultLatched)
    else $error("retry count exceeded without latching");
  a_retry_wait: assert property ( // see [R10]
    state_reg == ST_RETRY && demand && !waitDone |=> state_reg == ST_RETRY)
    else $error("retry left before its interval");
  a_latch_hold: assert property ( // see [R15]
    faultLatched && demand |=> faultLatched ##0 !outOn)
    else $error("latched fault released while demanded");

  c_latch: cover property (isOn ##1 faultLatched);
  c_retry_back: cover property (state_reg == ST_RETRY ##1 isOn);

endmodule : ofp_channel
`default_nettype wire

// ---- sim/ofp_load_model.sv ----
// ofp_load_model: sense path and power stage behind the fuse block
// assumes loads are set by the bench; an open switch draws nothing
`timescale 1ns/1ps
`default_nettype none
module ofp_load_model (
  input wire logic clk, // system clock
  input wire logic [ofp_pkg::NUM_CH-1:0] switchOn, // switch drives
  input wire logic [ofp_pkg::NUM_CH-1:0][ofp_pkg::CUR_W-1:0] loadMa, // load per output
  output logic [ofp_pkg::NUM_CH-1:0][ofp_pkg::CUR_W-1:0] curMa // sensed currents
);
  import ofp_pkg::*;
  initial curMa = '0;
  // sense lags the switch by one sample, so inrush is seen late, not early
  always @(posedge clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      curMa[c] <= switchOn[c] ? loadMa[c] : '0;
    end
  end
endmodule : ofp_load_model
`default_nettype wire

// ---- sim/output_fuse_protection_tb_top.sv ----
// output_fuse_protection_tb_top: bus, event and fuse scenarios on ofp_top
// assumes one 25 MHz clock and the load model on the sense side
`timescale 1ns/1ps
`default_nettype none
module output_fuse_protection_tb_top;
  import ofp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ofp_axi_req_t axiReq = '0;
  ofp_axi_rsp_t axiRsp;
  logic [NUM_CH-1:0][CUR_W-1:0] curMa;
  logic [NUM_CH-1:0][CUR_W-1:0] loadMa = '0;
  logic [NUM_CH-1:0] eventDemand = '0;
  logic [NUM_CH-1:0] switchOn;
  logic [31:0] rdat;
  logic [1:0] resp;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 25;
  int expMask = 0;
  int t;
  int oclMa[3] = '{15000, 20000, 25000};
  int cfgRst[4] = '{32'h00640002, 32'h001900fa, 32'h000332c8, 32'h00000064};

  always #20 clk = ~clk;

  ofp_top #(.NCH(NUM_CH)) i_dut (.clk(clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .curMa(curMa), .eventDemand(eventDemand), .switchOn(switchOn));
  ofp_load_model i_load (.clk(clk), .switchOn(switchOn), .loadMa(loadMa), .curMa(curMa));

  ////////////////////////////////////////////////////////////////////////
  // compare one value and count it
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // bus write: handshakes judged mid-cycle, released after the taking edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge clk);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    while (!hb) begin
      @(negedge clk);
      ha = axiReq.awvalid && axiRsp.awready;
      hw = axiReq.wvalid && axiRsp.wready;
      hb = axiRsp.bvalid;
      resp = axiRsp.bresp;
      @(posedge clk);
      if (ha) axiReq.awvalid <= 1'b0;
      if (hw) axiReq.wvalid <= 1'b0;
    end
    axiReq.bready <= 1'b0;
  endtask : wr

  // bus read: data sampled mid-cycle once rvalid is seen, with rready held high
  task automatic rd(input logic [31:0] a);
    logic ha, hr;
    hr = 1'b0;
    @(posedge clk);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    while (!hr) begin
      @(negedge clk);
      ha = axiReq.arvalid && axiRsp.arready;
      hr = axiRsp.rvalid;
      rdat = axiRsp.rdata;
      resp = axiRsp.rresp;
      @(posedge clk);
      if (ha) axiReq.arvalid <= 1'b0;
    end
    axiReq.rready <= 1'b0;
  endtask : rd

  // count cycles until a switch reaches a level, bounded
  task automatic waitSw(input int c, input logic v);
    t = 0;
    while (switchOn[c] !== v && t < 60000) begin
      @(negedge clk);
      t++;
    end
  endtask : waitSw

  // let a command land, then compare all switches with the model
  task automatic chkSw(input string what);
    repeat (3) @(negedge clk);
    chk(what, 32'(switchOn), 32'(expMask));
    @(posedge clk);
  endtask : chkSw

  function automatic logic [31:0] chAddr(input int c, input int w);
    return 32'(32'h100 + c * 32 + w * 4);
  endfunction : chAddr

  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset values of one channel, then an unmapped place
    for (int w = 0; w < 4; w++) begin
      rd(chAddr(0, w));
      chk("cfg reset", rdat, 32'(cfgRst[w]));
    end
    rd(32'h80);
    chk("unmapped read", 32'(resp), 32'(RESP_SLVERR));
    wr(32'h80, 32'h1);
    chk("unmapped write", 32'(resp), 32'(RESP_SLVERR));
    // event control with a random light load, current readback
    loadMa[2] <= 18'($random(seed) & 32'h1fff);
    eventDemand[2] <= 1'b1;
    expMask = 4;
    chkSw("event on");
    rd(chAddr(2, 4));
    chk("current", rdat, 32'(loadMa[2]));
    // manual mode: all off, toggles flip, leaving restores events
    wr(32'h0, 32'h1);
    expMask = 0;
    chkSw("manual entry");
    wr(32'hc, 32'h4);
    expMask = 4;
    chkSw("toggle on");
    wr(32'hc, 32'h4);
    expMask = 0;
    chkSw("toggle off");
    wr(32'h0, 32'h0);
    expMask = 4;
    chkSw("manual exit");
    // hard short on channel 1: inrush grace, trip, one retry, latch
    wr(chAddr(1, 2), 32'h000132c8);
    wr(chAddr(1, 3), 32'h00000001);
    loadMa[1] <= 18'h186a0;
    wr(32'h8, 32'h2);
    waitSw(1, 1'b1);
    waitSw(1, 1'b0);
    chk("inrush span", 32'(t >= 498 && t <= 510), 32'h1);
    waitSw(1, 1'b1);
    chk("retry gap", 32'(t <= 51000), 32'h1);
    waitSw(1, 1'b0);
    rd(32'h4);
    chk("latched", rdat, 32'h00020004);
    loadMa[1] <= '0;
    wr(32'h8, 32'h0);
    rd(32'h4);
    chk("latch cleared", rdat, 32'h00000004);
    // continuous limit at each select, current exactly at the limit
    wr(chAddr(3, 2), 32'h000032c8);
    for (int s = 0; s < 3; s++) begin
      wr(chAddr(3, 0), 32'h00030000 | s);
      loadMa[3] <= 18'(oclMa[s]);
      eventDemand[3] <= 1'b1;
      waitSw(3, 1'b1);
      waitSw(3, 1'b0);
      chk("ocl window", 32'(t >= 2400 && t <= 3900), 32'h1);
      @(posedge clk);
      eventDemand[3] <= 1'b0;
      repeat (5) @(posedge clk);
    end
    chkSw("others untouched");
    conclude();
  end

  // watchdog against a hung handshake or switch
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : output_fuse_protection_tb_top
`default_nettype wire
